// ===== watch_timer_pkg.sv
`default_nettype none

package watch_timer_pkg;

    // -------------------------------------------------------------------
    // Register bus
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_MASK    = 4'h2;

    // -------------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------------
    localparam int unsigned BIT_COUNT_CLOCK_SELECT   = 0;
    localparam int unsigned BIT_FAST_INTERVAL_SELECT = 1;
    localparam int unsigned BIT_TIMEKEEPING_RUN      = 2;
    localparam int unsigned BIT_BUZZER_FREQ_LOW      = 4;
    localparam int unsigned BIT_BUZZER_FREQ_HIGH     = 5;
    localparam int unsigned BIT_BUZZER_OUTPUT_ENABLE = 7;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CONTROL_WMASK = 8'hB7;

    // Status and mask layout: bit 0 is the timekeeping interval flag.
    localparam int unsigned BIT_INTERVAL_FLAG = 0;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MASK_RESET   = 8'h00;

    // -------------------------------------------------------------------
    // Divider chain
    // -------------------------------------------------------------------
    localparam int unsigned PRESCALE_W = 7;
    localparam int unsigned NORMAL_W   = 14;
    localparam int unsigned FAST_W     = 7;
    localparam int unsigned BUZ_DIV16_BIT = 3;
    localparam int unsigned BUZ_DIV8_BIT  = 2;

    // Buzzer frequency codes.
    localparam logic [1:0] BUZ_DIV16    = 2'h0;
    localparam logic [1:0] BUZ_DIV8     = 2'h1;
    localparam logic [1:0] BUZ_ILLEGAL  = 2'h2;
    localparam logic [1:0] BUZ_FW       = 2'h3;

endpackage

`default_nettype wire

// ===== tick_divider.sv
`default_nettype none

// Binary counter advanced by single-cycle ticks, with a synchronous clear.
module tick_divider #(
    parameter int unsigned WIDTH = 7
) (
    input  wire logic             ref_clk,  // System clock.
    input  wire logic             reset_n,  // Asynchronous reset, low.
    input  wire logic             clear,    // Holds the count at zero.
    input  wire logic             tick,     // Advance by one.
    output logic [WIDTH-1:0]      count,    // Current count.
    output logic                  wrap      // Tick that rolls over.
);

    // -------------------------------------------------------------------
    // Counter
    // -------------------------------------------------------------------

    // Rollover is seen combinationally so the caller flags in step.
    assign wrap = tick && !clear && (count == {WIDTH{1'b1}});

    // Clear dominates counting.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

endmodule

`default_nettype wire

// ===== watch_interval_timer.sv
// Strobed register access and the placing of the registers were chosen for this implementation.
`default_nettype none

module watch_interval_timer
    import watch_timer_pkg::*;
(
    input  wire logic                              ref_clk,           // Clock.
    input  wire logic                              reset_n,           // Reset.
    input  wire logic [watch_timer_pkg::ADDR_W-1:0] addr,             // Addr.
    input  wire logic [watch_timer_pkg::DATA_W-1:0] wdata,            // Data.
    input  wire logic                              wr,                // Write.
    input  wire logic                              rd,                // Read.
    output logic      [watch_timer_pkg::DATA_W-1:0] rdata,            // Data.
    input  wire logic                              main_clock_input,  // Main.
    input  wire logic                              subsystem_clock,   // Sub.
    output logic                                   buzzer_pin,        // Buzz.
    output logic                                   buzzer_oe,         // Drive.
    output logic                                   standby_release,   // Wake.
    output logic                                   irq                // Int.
);
    import watch_timer_pkg::*;

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [DATA_W-1:0]     watch_control_register;
    logic [DATA_W-1:0]     status_reg;
    logic [DATA_W-1:0]     mask_reg;
    logic                  main_clk_reg;
    logic                  sub_clk_reg;
    logic                  main_rise;
    logic                  sub_rise;
    logic [PRESCALE_W-1:0] prescale_count;
    logic                  prescale_wrap;
    logic                  watch_tick;
    logic                  watch_count_clock;
    logic [NORMAL_W-1:0]   div_count;
    logic                  div_wrap;
    logic                  interval_event;
    logic                  flag_clear;
    logic                  buzzer_next;
    logic                  count_clock_select;
    logic                  fast_interval_select;
    logic                  timekeeping_run;
    logic [1:0]            buzzer_freq_select;
    logic                  buzzer_output_enable;
    logic                  timekeeping_interval_flag;

    // Field views of the control register.
    assign count_clock_select   =
        watch_control_register[BIT_COUNT_CLOCK_SELECT];
    assign fast_interval_select =
        watch_control_register[BIT_FAST_INTERVAL_SELECT];
    assign timekeeping_run      = watch_control_register[BIT_TIMEKEEPING_RUN];
    assign buzzer_freq_select   = {
        watch_control_register[BIT_BUZZER_FREQ_HIGH],
        watch_control_register[BIT_BUZZER_FREQ_LOW]};
    assign buzzer_output_enable =
        watch_control_register[BIT_BUZZER_OUTPUT_ENABLE];
    assign timekeeping_interval_flag = status_reg[BIT_INTERVAL_FLAG];

    // -------------------------------------------------------------------
    // Control register
    // -------------------------------------------------------------------

    // A write replaces bits 0-2, 4, 5 and 7 at once and zeroes bits 3 and 6; reset clears them all.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            watch_control_register <= CONTROL_RESET;
        end else if (wr && addr == ADDR_CONTROL) begin
            watch_control_register <= wdata & CONTROL_WMASK;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= MASK_RESET;
        end else if (wr && addr == ADDR_MASK) begin
            mask_reg <= wdata & 8'h01;
        end
    end

    // -------------------------------------------------------------------
    // Count clock selection
    // -------------------------------------------------------------------

    // Input clocks are sampled levels; a rising edge gives one tick.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_clk_reg <= 1'b0;
            sub_clk_reg  <= 1'b0;
        end else begin
            main_clk_reg <= main_clock_input;
            sub_clk_reg  <= subsystem_clock;
        end
    end

    assign main_rise = main_clock_input && !main_clk_reg;
    assign sub_rise  = subsystem_clock && !sub_clk_reg;

    // Main clock prescaler by 128, running freely.
    tick_divider #(
        .WIDTH (PRESCALE_W)
    ) u_prescale (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clear   (1'b0),
        .tick    (main_rise),
        .count   (prescale_count),
        .wrap    (prescale_wrap)
    );

    // Either source feeds the same divider, so both give half a second.
    assign watch_tick = count_clock_select ? sub_rise
                                           : prescale_wrap;
    assign watch_count_clock = count_clock_select
        ? sub_clk_reg : prescale_count[PRESCALE_W-1];

    // -------------------------------------------------------------------
    // Frequency divider
    // -------------------------------------------------------------------

    // Divider is held cleared while timekeeping is stopped.
    tick_divider #(
        .WIDTH (NORMAL_W)
    ) u_divider (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clear   (!timekeeping_run),
        .tick    (watch_tick),
        .count   (div_count),
        .wrap    (div_wrap)
    );

    // Normal mode ends each 2^14 count; fast mode each 2^7 count.
    assign interval_event = fast_interval_select
        ? (watch_tick && timekeeping_run &&
           div_count[FAST_W-1:0] == {FAST_W{1'b1}})
        : div_wrap;

    // -------------------------------------------------------------------
    // Interval flag and interrupt
    // -------------------------------------------------------------------

    assign flag_clear = wr && addr == ADDR_STATUS && wdata[BIT_INTERVAL_FLAG];

    // Sticky flag: a new interval wins over a clear in the same cycle.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= STATUS_RESET;
        end else if (interval_event) begin
            status_reg[BIT_INTERVAL_FLAG] <= 1'b1;
        end else if (flag_clear) begin
            status_reg[BIT_INTERVAL_FLAG] <= 1'b0;
        end
    end

    // Standby release follows the flag one cycle later; the interrupt follows the flag ANDed with the mask.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq             <= 1'b0;
            standby_release <= 1'b0;
        end else begin
            irq             <= |(status_reg & mask_reg);
            standby_release <= timekeeping_interval_flag;
        end
    end

    // -------------------------------------------------------------------
    // Buzzer output
    // -------------------------------------------------------------------

    // The reserved code drives a steady low.
    always_comb begin
        case (buzzer_freq_select)
            BUZ_DIV16: buzzer_next = div_count[BUZ_DIV16_BIT];
            BUZ_DIV8:  buzzer_next = div_count[BUZ_DIV8_BIT];
            BUZ_FW:    buzzer_next = watch_count_clock;
            default:   buzzer_next = 1'b0;
        endcase
    end

    // Pin is low and undriven while the buzzer is disabled.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            buzzer_pin <= 1'b0;
            buzzer_oe  <= 1'b0;
        end else begin
            buzzer_pin <= buzzer_output_enable && buzzer_next;
            buzzer_oe  <= buzzer_output_enable;
        end
    end

    // -------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                ADDR_CONTROL: rdata <= watch_control_register;
                ADDR_STATUS:  rdata <= status_reg;
                ADDR_MASK:    rdata <= mask_reg;
                default:      rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------

    // Normal interval: full 14-bit rollover sets the flag.
    property p_normal_interval;
        @(posedge ref_clk) disable iff (!reset_n)
        (watch_tick && timekeeping_run && !fast_interval_select &&
         div_count == 14'h3FFF) |=> (timekeeping_interval_flag &&
                                     div_count == 14'h0000);
    endproperty
    a_normal_interval: assert property (p_normal_interval)
        else $error("Normal interval did not set the flag.");

    // Normal mode never flags mid-count.
    property p_normal_no_early;
        @(posedge ref_clk) disable iff (!reset_n)
        (!fast_interval_select && !timekeeping_interval_flag &&
         !(watch_tick && div_count == 14'h3FFF))
        |=> !timekeeping_interval_flag;
    endproperty
    a_normal_no_early: assert property (p_normal_no_early)
        else $error("Flag set before the interval ended.");

    // Fast interval: seven-bit rollover sets the flag.
    property p_fast_interval;
        @(posedge ref_clk) disable iff (!reset_n)
        (watch_tick && timekeeping_run && fast_interval_select &&
         div_count[6:0] == 7'h7F) |=> timekeeping_interval_flag;
    endproperty
    a_fast_interval: assert property (p_fast_interval)
        else $error("Fast interval did not set the flag.");

    // Subsystem edges advance the divider directly.
    property p_sub_source;
        @(posedge ref_clk) disable iff (!reset_n)
        (count_clock_select && timekeeping_run && sub_rise &&
         !$changed(watch_control_register))
        |=> div_count == $past(div_count) + 14'h0001;
    endproperty
    a_sub_source: assert property (p_sub_source)
        else $error("Subsystem edge did not advance the divider.");

    // Stopped timekeeping keeps the divider at zero.
    property p_stop_clears;
        @(posedge ref_clk) disable iff (!reset_n)
        !timekeeping_run |=> div_count == 14'h0000;
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("Divider not cleared while stopped.");

    // Standby release follows the flag.
    property p_wake;
        @(posedge ref_clk) disable iff (!reset_n)
        timekeeping_interval_flag |=> standby_release;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Flag did not release standby.");

    // Divide-by-16 selection tracks divider bit three.
    property p_buz_div16;
        @(posedge ref_clk) disable iff (!reset_n)
        (buzzer_output_enable && buzzer_freq_select == 2'h0)
        |=> buzzer_pin == $past(div_count[3]);
    endproperty
    a_buz_div16: assert property (p_buz_div16)
        else $error("Buzzer does not follow divide-by-16.");

    // Disabled buzzer stays low and undriven.
    property p_buz_off;
        @(posedge ref_clk) disable iff (!reset_n)
        !buzzer_output_enable |=> (!buzzer_pin && !buzzer_oe);
    endproperty
    a_buz_off: assert property (p_buz_off)
        else $error("Buzzer active while disabled.");

    // First cycle after reset release shows a cleared control register.
    property p_reset_clear;
        @(posedge ref_clk)
        $rose(reset_n) |-> watch_control_register == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Control register not cleared by reset.");

    // A control write lands whole in the next cycle.
    property p_whole_write;
        @(posedge ref_clk) disable iff (!reset_n)
        (wr && addr == ADDR_CONTROL)
        |=> watch_control_register == ($past(wdata) & 8'hB7);
    endproperty
    a_whole_write: assert property (p_whole_write)
        else $error("Control write not taken whole.");

    // Flag holds until cleared by a write of one.
    property p_sticky;
        @(posedge ref_clk) disable iff (!reset_n)
        (timekeeping_interval_flag && !flag_clear)
        |=> timekeeping_interval_flag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Flag dropped without a clear.");

    // Coverage of the main scenarios.
    c_normal: cover property (@(posedge ref_clk) disable iff (!reset_n)
        div_wrap && !fast_interval_select);
    c_fast: cover property (@(posedge ref_clk) disable iff (!reset_n)
        interval_event && fast_interval_select);
    c_set_beats_clear: cover property (@(posedge ref_clk)
        disable iff (!reset_n) interval_event && flag_clear);
    c_buzzer: cover property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(buzzer_pin));

endmodule

`default_nettype wire

// ===== buzzer_monitor.sv
`default_nettype none

// ---------------------------------------------------------------------------
// Buzzer observer
// ---------------------------------------------------------------------------
// Stands in for the sounder or the trimming counter on the buzzer pin.
module buzzer_monitor (
    input  wire logic        ref_clk,    // System clock.
    input  wire logic        reset_n,    // Asynchronous reset, low.
    input  wire logic        clear,      // Restarts the edge count.
    input  wire logic        buzzer_pin, // Observed buzzer level.
    output logic      [15:0] rise_count  // Rising edges seen.
);
    timeunit 1ns;
    timeprecision 100ps;

    logic pin_prev_reg; // Pin level one cycle back.

    // Counts every rising edge, enabled or not, as a counter on the pin would.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_prev_reg <= 1'b0;
            rise_count   <= 16'h0000;
        end else begin
            pin_prev_reg <= buzzer_pin;
            if (clear) begin
                rise_count <= 16'h0000;
            end else if (buzzer_pin && !pin_prev_reg) begin
                rise_count <= rise_count + 16'h0001;
            end
        end
    end
endmodule

`default_nettype wire

// ===== testbench.sv
`default_nettype none

// ---------------------------------------------------------------------------
// Testbench
// ---------------------------------------------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import watch_timer_pkg::*;

    logic              ref_clk, reset_n, wr, rd, mon_clear;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic              main_clock_input, subsystem_clock;
    logic              buzzer_pin, buzzer_oe, standby_release, irq;
    logic [15:0]       rise_count;
    int                mismatches, samples_checked, i;

    // Buzzer setups: codes 00, 01, 11 on the subsystem clock, code 11 on
    // the idle main clock path, then code 00 with the buzzer disabled.
    localparam logic [7:0]  BUZ_CTRL [5] = '{8'h85, 8'h95, 8'hB5, 8'hB4,
                                             8'h05};
    localparam logic [15:0] BUZ_RISE [5] = '{16'h0004, 16'h0008, 16'h0040,
                                             16'h0000, 16'h0000};

    watch_interval_timer DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .main_clock_input(main_clock_input),
        .subsystem_clock(subsystem_clock), .buzzer_pin(buzzer_pin),
        .buzzer_oe(buzzer_oe), .standby_release(standby_release), .irq(irq)
    );

    buzzer_monitor sounder (
        .ref_clk(ref_clk), .reset_n(reset_n), .clear(mon_clear),
        .buzzer_pin(buzzer_pin), .rise_count(rise_count)
    );

    // Free-running 200 MHz clock.
    always #2.5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim;
        $display("compared %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compares one value with case equality and counts it.
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // One-cycle write strobe.
    task automatic reg_write(input logic [ADDR_W-1:0] a,
                             input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data are taken in the following cycle.
    task automatic reg_read(input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] exp, input string msg);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp}, msg);
    endtask

    // Gives n rising edges on the main or the subsystem clock input.
    task automatic edges(input logic use_main, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge ref_clk);
            main_clock_input <= use_main;
            subsystem_clock  <= !use_main;
            @(posedge ref_clk);
            main_clock_input <= 1'b0;
            subsystem_clock  <= 1'b0;
        end
    endtask

    // Lets the sampling pipeline settle, then checks the interval flag.
    task automatic flag_is(input logic exp, input string msg);
        repeat (6) @(posedge ref_clk);
        #1;
        check({15'h0000, standby_release}, {15'h0000, exp}, msg);
        reg_read(ADDR_STATUS, {7'h00, exp}, msg);
    endtask

    // Stops the divider and clears a pending flag.
    task automatic restart;
        reg_write(ADDR_CONTROL, 8'h00);
        reg_write(ADDR_STATUS, 8'h01);
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    // Register access, fast and normal intervals, buzzer codes, main path.
    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        mon_clear = 1'b0;
        main_clock_input = 1'b0;
        subsystem_clock = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_read(ADDR_CONTROL, CONTROL_RESET, "control reset");
        reg_read(ADDR_STATUS, STATUS_RESET, "status reset");
        reg_read(ADDR_MASK, MASK_RESET, "mask reset");
        check({15'h0000, buzzer_oe}, 16'h0000, "buzzer off");
        reg_write(ADDR_CONTROL, 8'hFF);
        reg_read(ADDR_CONTROL, 8'hB7, "control whole");
        reg_write(4'h3, 8'hFF);
        reg_read(4'h3, 8'h00, "unmapped");
        reg_write(ADDR_MASK, 8'hFF);
        reg_read(ADDR_MASK, 8'h01, "mask bits");
        reg_write(ADDR_MASK, 8'h00);
        restart();
        $display("test registers done");
        reg_write(ADDR_CONTROL, 8'h07);
        edges(1'b0, 127);
        flag_is(1'b0, "fast early");
        edges(1'b0, 1);
        flag_is(1'b1, "fast flag");
        check({15'h0000, irq}, 16'h0000, "irq masked");
        reg_write(ADDR_MASK, 8'h01);
        flag_is(1'b1, "flag held");
        check({15'h0000, irq}, 16'h0001, "irq raised");
        reg_write(ADDR_STATUS, 8'h01);
        flag_is(1'b0, "flag cleared");
        check({15'h0000, irq}, 16'h0000, "irq cleared");
        edges(1'b0, 128);
        flag_is(1'b1, "flag again");
        reg_write(ADDR_STATUS, 8'h01);
        $display("test fast done");
        edges(1'b0, 100);
        reg_write(ADDR_CONTROL, 8'h03);
        edges(1'b0, 20);
        reg_write(ADDR_CONTROL, 8'h07);
        edges(1'b0, 127);
        flag_is(1'b0, "run clears");
        edges(1'b0, 1);
        flag_is(1'b1, "run restart");
        $display("test run done");
        for (i = 0; i < 5; i++) begin
            restart();
            reg_write(ADDR_CONTROL, BUZ_CTRL[i]);
            @(posedge ref_clk);
            mon_clear <= 1'b1;
            @(posedge ref_clk);
            mon_clear <= 1'b0;
            edges(1'b0, 64);
            repeat (6) @(posedge ref_clk);
            #1;
            check(rise_count, BUZ_RISE[i], "buzzer edges");
            check({15'h0000, buzzer_oe}, {15'h0000, BUZ_CTRL[i][7]},
                  "buzzer drive");
        end
        $display("test buzzer done");
        restart();
        reg_write(ADDR_CONTROL, 8'h05);
        edges(1'b0, 16383);
        flag_is(1'b0, "normal early");
        edges(1'b0, 1);
        flag_is(1'b1, "normal flag");
        $display("test normal done");
        restart();
        reg_write(ADDR_CONTROL, 8'h06);
        edges(1'b1, 16383);
        flag_is(1'b0, "main early");
        edges(1'b1, 1);
        flag_is(1'b1, "main flag");
        $display("test main clock done");
        end_sim();
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        end_sim();
    end
endmodule

`default_nettype wire
